// >>> common/uart_cfg.svh
/*
  register addresses, bit positions, the data reset value and timing counts of the
  serial port. assumes an 8-bit special-function bus and a secondary bus.
*/
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// ****************
// addresses and the data reset value
// ****************
`define ADR_BDH 8'h60
`define ADR_BDL 8'h61
`define ADR_FLAGS 8'h98
`define ADR_C2 8'hba
`define ADR_C3 8'hbb
`define ADR_S2 8'hbc
`define ADR_DATA 8'hbd
`define ADR_CLR 8'hc2
`define ADR_C1 8'hed
`define RST_DATA 8'hff
// ****************
// bit positions
// ****************
`define F_TE 7
`define F_TF 6
`define F_RI 5
`define F_IDLE 4
`define F_OR 3
`define F_NF 2
`define F_FE 1
`define F_PE 0
`define C2_TE 3
`define C2_RE 2
`define C2_RWU 1
`define C2_BRK 0
`define C3_DIR 5
`define C3_TINV 4
`define C3_RINV 3
`define C3_RWUIDLE 2
`define C3_IDLESEL 1
`define C3_WAKE 0
`define S2_BRK_IE 3
`define S2_EDGE_IE 2
`define S2_LONG 1
`define S2_BRK_EN 0
`define C1_LOOP 7
`define C1_STOP2 6
`define C1_SINGLE 5
`define C1_NINE 4
`define C1_PEN 3
`define C1_ODD 2
`define C1_EN 0
// ****************
// bit-time and sample-tick counts
// ****************
`define CHAR_LEN 4'ha
`define BRK_TX_LONG 4'hd
`define BRK_RX_LEN 4'hb
`define DATA_BITS 4'h8
`define RT_START 4'h2
`define RT_S1 4'h8
`define RT_S2 4'h9
`define RT_S3 4'ha
`define RT_LAST 4'hf
`define EDGE_ONES 2'h3
`endif

// >>> common/uart_pkg.sv
/*
  types of the serial port: state encodings and the packed state record.
  assumes uart_cfg.svh carries all numbers.
*/
package uart_pkg;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_SHIFT = 2'h2
  } tx_state_t;
  typedef struct packed {
    logic [4:0] bdh;
    logic [7:0] bdl, c1, c2, c3, flags, rxbuf, rdata;
    logic [3:0] s2;
    logic brk_if, edge_if, rx_ninth_bit, irq, txd, txd_oe_n;
    logic [2:0] sync, samp;
    logic lvl, rx_prev, noise, armed, brk_pend;
    logic [1:0] ones;
    rx_state_t rxst;
    logic [3:0] rt, bitn, icnt, bcnt;
    logic [8:0] rxsr;
    tx_state_t txst;
    logic [3:0] txrt, txn;
    logic [11:0] txsr;
  } main_state_t;
endpackage

// >>> hdl/uart_baud.sv
/*
  sixteen-times baud tick generator.
  assumes a static divisor; zero stops the tick.
*/
module uart_baud #(
  parameter int DIV_W = 13
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tick16_o
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } baud_state_t;
  baud_state_t q, ns;
  always_comb
  begin
    ns = q;
    ns.tick = 1'b0;
    if (!en_i || div_i == '0)
      ns.cnt = '0;
    else if (q.cnt >= div_i - DIV_W'(1))
    begin
      ns.cnt = '0;
      ns.tick = 1'b1;
    end
    else
      ns.cnt = q.cnt + DIV_W'(1);
  end
  always_ff @(posedge sys_clk_i)
    if (rst_i)
      q <= '0;
    else
      q <= ns;
  assign tick16_o = q.tick;
endmodule

// >>> hdl/uart_buf2.sv
/*
  two-entry buffer with valid and ready on both sides.
  assumes flush is a level that empties it.
*/
module uart_buf2 #(
  parameter int W = 9
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wr, rd;
    logic [1:0] cnt;
  } buf_state_t;
  buf_state_t q, ns;
  logic push, pop;
  assign in_ready_o = q.cnt != 2'h2;
  assign out_valid_o = q.cnt != 2'h0;
  assign out_data_o = q.mem[q.rd];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always_comb
  begin
    ns = q;
    if (push)
      ns.mem[q.wr] = in_data_i;
    ns.wr = q.wr ^ push;
    ns.rd = q.rd ^ pop;
    case ({push, pop})
      2'b10: ns.cnt = q.cnt + 2'h1;
      2'b01: ns.cnt = q.cnt - 2'h1;
      default: ns.cnt = q.cnt;
    endcase
    if (flush_i)
    begin
      ns.cnt = 2'h0;
      ns.wr = 1'b0;
      ns.rd = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i)
    if (rst_i)
      q <= '0;
    else
      q <= ns;
endmodule

// >>> hdl/uart_regs.sv
/*
  serial port: registers, flags, transmitter, receiver, break and idle logic.
  assumes the processor strobes one register access per cycle; pins are
  asynchronous and pass a three-stage synchroniser.
*/
`include "uart_cfg.svh"
module uart_regs (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic xbus_sel_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe_n_o,
  output logic irq_o
);
  uart_pkg::main_state_t q, ns;
  logic tick, sfr_wr, sfr_rd, sec_wr, sec_rd, nine, two, single, loop;
  logic pin_raw, rx_in, maj, noisy, standby, tx_par, idle_hit;
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_pop;
  logic [2:0] s3;
  logic [8:0] buf_out, d9;
  logic [7:0] tx_byte;
  logic [3:0] idle_len, brk_rx_len;

  function automatic logic [3:0] frame_len(input logic [3:0] base, input logic n,
                                           input logic t);
    frame_len = base + {3'h0, n} + {3'h0, t};
  endfunction

  function automatic logic par_of(input logic [7:0] d, input logic n, input logic odd);
    par_of = (n ? ^d : ^d[6:0]) ^ odd;
  endfunction

  // ****************
  // decode
  // ****************
  assign sfr_wr = reg_wr_i & ~xbus_sel_i;
  assign sfr_rd = reg_rd_i & ~xbus_sel_i;
  assign sec_wr = reg_wr_i & xbus_sel_i;
  assign sec_rd = reg_rd_i & xbus_sel_i;
  assign nine = q.c1[`C1_NINE];
  assign two = q.c1[`C1_STOP2];
  assign single = q.c1[`C1_SINGLE];
  assign loop = q.c1[`C1_LOOP];
  assign standby = q.c2[`C2_RWU];
  assign idle_len = frame_len(`CHAR_LEN, nine, two);
  assign brk_rx_len = frame_len(`BRK_RX_LEN, nine, two);

  // ****************
  // line paths
  // ****************
  assign pin_raw = (loop & single) ? txd_i : rxd_i;
  // in single-wire output mode the receiver hears its own transmitter
  assign rx_in = ((loop & (~single | q.c3[`C3_DIR])) ? q.txd : q.lvl)
                 ^ q.c3[`C3_RINV];
  assign s3 = {q.samp[1:0], rx_in};
  assign maj = (s3[0] & s3[1]) | (s3[0] & s3[2]) | (s3[1] & s3[2]);
  assign noisy = ~(&s3 | ~|s3);
  assign d9 = nine ? q.rxsr : {1'b0, q.rxsr[8:1]};

  // ****************
  // baud and transmit buffer
  // ****************
  uart_baud #(.DIV_W(13)) baud_gen (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .en_i(q.c1[`C1_EN]),
    .div_i({q.bdh, q.bdl}),
    .tick16_o(tick)
  );

  assign buf_in_valid = sfr_wr & (reg_addr_i == `ADR_DATA);
  assign buf_pop = tick & (q.txst == uart_pkg::TX_IDLE) & q.c2[`C2_TE] & ~q.brk_pend;
  assign tx_par = par_of(buf_out[7:0], nine, q.c1[`C1_ODD]);
  assign tx_byte = (q.c1[`C1_PEN] & ~nine) ? {tx_par, buf_out[6:0]} : buf_out[7:0];

  // a stalled shifter holds words here; writes beyond two are refused
  uart_buf2 #(.W(9)) tx_buf (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flush_i(~q.c2[`C2_TE]),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i({q.c3[6], reg_wdata_i}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out)
  );

  // ****************
  // next state
  // ****************
  always_comb
  begin
    ns = q;
    idle_hit = 1'b0;
    ns.sync = {q.sync[1:0], pin_raw};
    if (q.sync[1] == q.sync[2])
      ns.lvl = q.sync[2];
    ns.rx_prev = rx_in;
    ns.txd_oe_n = loop & ~(single & q.c3[`C3_DIR]);
    // software writes come first so that hardware sets win
    if (sfr_wr)
    begin
      case (reg_addr_i)
        `ADR_C2:
        begin
          if (q.c2[`C2_BRK] && !reg_wdata_i[`C2_BRK])
            ns.brk_pend = 1'b1;
          ns.c2 = reg_wdata_i;
        end
        `ADR_C3: ns.c3 = reg_wdata_i;
        `ADR_S2:
        begin
          ns.s2 = reg_wdata_i[3:0];
          if (reg_wdata_i[7])
            ns.brk_if = 1'b0;
          if (reg_wdata_i[6])
            ns.edge_if = 1'b0;
        end
        `ADR_CLR: ns.flags = q.flags & ~reg_wdata_i;
        `ADR_C1: ns.c1 = reg_wdata_i;
        default: ;
      endcase
    end
    if (sec_wr && reg_addr_i == `ADR_BDH)
      ns.bdh = reg_wdata_i[4:0];
    if (sec_wr && reg_addr_i == `ADR_BDL)
      ns.bdl = reg_wdata_i;
    if (sfr_rd)
    begin
      case (reg_addr_i)
        `ADR_FLAGS: ns.rdata = q.flags;
        `ADR_C2: ns.rdata = q.c2;
        `ADR_C3: ns.rdata = {q.rx_ninth_bit, q.c3[6:0]};
        `ADR_S2: ns.rdata = {q.brk_if, q.edge_if, q.rxst != uart_pkg::RX_IDLE, 1'b0, q.s2};
        `ADR_DATA:
        begin
          ns.rdata = q.rxbuf;
          ns.flags[`F_RI] = 1'b0;
        end
        `ADR_CLR: ns.rdata = 8'h00;
        `ADR_C1: ns.rdata = q.c1;
        default: ns.rdata = 8'h00;
      endcase
    end
    if (sec_rd)
      ns.rdata = (reg_addr_i == `ADR_BDH) ? {3'h0, q.bdh} :
                 (reg_addr_i == `ADR_BDL) ? q.bdl : 8'h00;

    // ****************
    // receiver
    // ****************
    if (!q.c2[`C2_RE])
    begin
      ns.rxst = uart_pkg::RX_IDLE;
      ns.ones = 2'h0;
      ns.icnt = 4'h0;
      ns.bcnt = 4'h0;
    end
    else
    begin
      if (q.rx_prev && !rx_in)
        ns.edge_if = 1'b1;
      if (tick)
      begin
        ns.rt = q.rt + 4'h1;
        if (q.rt == `RT_S1 || q.rt == `RT_S2 || q.rt == `RT_S3)
          ns.samp = s3;
        // idle counting: origin after stop bit only counts outside frames
        if (!rx_in)
          ns.icnt = 4'h0;
        else if (q.rt == `RT_LAST && q.icnt != idle_len &&
                 (!q.c3[`C3_IDLESEL] || q.rxst == uart_pkg::RX_IDLE))
        begin
          ns.icnt = q.icnt + 4'h1;
          idle_hit = (q.icnt + 4'h1) == idle_len;
        end
        if (idle_hit)
        begin
          if (standby && !q.c3[`C3_WAKE])
            ns.c2[`C2_RWU] = 1'b0;
          if (q.armed && (!standby || q.c3[`C3_RWUIDLE]))
            ns.flags[`F_IDLE] = 1'b1;
          ns.armed = 1'b0;
        end
        // break: consecutive low bit times, a high level restarts the count
        if (rx_in)
          ns.bcnt = 4'h0;
        else if (q.rt == `RT_LAST && q.bcnt != brk_rx_len)
        begin
          ns.bcnt = q.bcnt + 4'h1;
          if ((q.bcnt + 4'h1) == brk_rx_len && q.s2[`S2_BRK_EN])
            ns.brk_if = 1'b1;
        end
        case (q.rxst)
          uart_pkg::RX_IDLE:
          begin
            if (rx_in)
              ns.ones = (q.ones == `EDGE_ONES) ? q.ones : q.ones + 2'h1;
            else
            begin
              ns.ones = 2'h0;
              if (q.ones == `EDGE_ONES)
              begin
                ns.rxst = uart_pkg::RX_START;
                ns.rt = `RT_START;
                ns.noise = 1'b0;
                ns.bitn = 4'h0;
              end
            end
          end
          uart_pkg::RX_START:
          begin
            if (q.rt == `RT_S3)
            begin
              ns.rxst = maj ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
              ns.noise = noisy;
            end
          end
          uart_pkg::RX_DATA:
          begin
            if (q.rt == `RT_S3)
            begin
              ns.rxsr = {maj, q.rxsr[8:1]};
              ns.bitn = q.bitn + 4'h1;
              ns.noise = q.noise | noisy;
              if ((q.bitn + 4'h1) == (`DATA_BITS + {3'h0, nine}))
                ns.rxst = uart_pkg::RX_STOP;
            end
          end
          uart_pkg::RX_STOP:
          begin
            if (q.rt == `RT_S3)
            begin
              ns.rxst = uart_pkg::RX_IDLE;
              // standby drops characters until an address mark arrives, or with idle wake until an idle line clears it
              if (!standby || (q.c3[`C3_WAKE] && (nine ? d9[8] : d9[7])))
              begin
                ns.c2[`C2_RWU] = 1'b0;
                ns.armed = 1'b1;
                if (ns.flags[`F_RI])
                  ns.flags[`F_OR] = 1'b1;
                else
                begin
                  ns.rxbuf = d9[7:0];
                  ns.rx_ninth_bit = d9[8];
                  ns.flags[`F_RI] = 1'b1;
                  if (q.noise | noisy)
                    ns.flags[`F_NF] = 1'b1;
                  if (!maj)
                    ns.flags[`F_FE] = 1'b1;
                  if (q.c1[`C1_PEN] && ((nine ? d9[8] : d9[7]) !=
                      par_of(d9[7:0], nine, q.c1[`C1_ODD])))
                    ns.flags[`F_PE] = 1'b1;
                end
              end
            end
          end
          default: ns.rxst = uart_pkg::RX_IDLE;
        endcase
      end
    end

    // ****************
    // transmitter
    // ****************
    if (tick)
    begin
      case (q.txst)
        uart_pkg::TX_IDLE:
        begin
          ns.txrt = 4'h0;
          if (q.c2[`C2_TE] && q.brk_pend)
          begin
            ns.txsr = 12'h000;
            ns.txn = frame_len(q.s2[`S2_LONG] ? `BRK_TX_LONG : `CHAR_LEN, nine, two);
            ns.brk_pend = 1'b0;
            ns.txst = uart_pkg::TX_SHIFT;
          end
          else if (buf_pop && buf_out_valid)
          begin
            ns.txsr = {2'b11, nine ? (q.c1[`C1_PEN] ? tx_par : buf_out[8]) : 1'b1,
                       tx_byte, 1'b0};
            ns.txn = frame_len(`CHAR_LEN, nine, two);
            ns.txst = uart_pkg::TX_SHIFT;
          end
        end
        uart_pkg::TX_SHIFT:
        begin
          // a started character finishes even if the transmitter is switched off
          ns.txrt = q.txrt + 4'h1;
          if (q.txrt == `RT_LAST)
          begin
            ns.txsr = {q.txsr[11], q.txsr[11:1]};
            ns.txn = q.txn - 4'h1;
            if (q.txn == 4'h1)
              ns.txst = uart_pkg::TX_IDLE;
          end
        end
        default: ns.txst = uart_pkg::TX_IDLE;
      endcase
    end
    ns.txd = ((ns.txst == uart_pkg::TX_SHIFT) ? ns.txsr[0] : 1'b1)
             ^ q.c3[`C3_TINV];
    // these two follow their condition, so a clear only holds while it is false
    ns.flags[`F_TE] = q.c2[`C2_TE] & buf_in_ready;
    ns.flags[`F_TF] = q.c2[`C2_TE] & (q.txst == uart_pkg::TX_IDLE) & ~buf_out_valid
                      & ~q.brk_pend;
    ns.irq = |(ns.flags[7:4] & ns.c2[7:4]) |
             (ns.brk_if & ns.s2[`S2_BRK_IE]) | (ns.edge_if & ns.s2[`S2_EDGE_IE]);
  end

  // ****************
  // state register
  // ****************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.rxbuf <= `RST_DATA;
      q.rdata <= `RST_DATA;
      q.txd <= 1'b1;
      q.sync <= 3'h7;
      q.lvl <= 1'b1;
      q.rx_prev <= 1'b1;
      q.rxst <= uart_pkg::RX_IDLE;
      q.txst <= uart_pkg::TX_IDLE;
    end
    else
      q <= ns;
  end

  assign reg_rdata_o = q.rdata;
  assign txd_o = q.txd;
  assign txd_oe_n_o = q.txd_oe_n;
  assign irq_o = q.irq;
endmodule

// >>> test/uart_regs_monitor.sv
/*
  pin and register-bus checks for the serial port.
  assumes it is bound to uart_regs and sees only its ports.
*/
`include "uart_cfg.svh"
module uart_regs_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic xbus_sel_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic rxd_i,
  input wire logic txd_i,
  input wire logic txd_o,
  input wire logic txd_oe_n_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c1_q;
  logic [3:0] c2e_q;
  logic [1:0] s2e_q;
  logic inv_q;
  logic tx_used_q;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // ****
  // shadow of written controls
  // ****
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      c1_q <= 8'h00;
      c2e_q <= 4'h0;
      s2e_q <= 2'h0;
      inv_q <= 1'b0;
      tx_used_q <= 1'b0;
    end
    else if (reg_wr_i && !xbus_sel_i)
    begin
      if (reg_addr_i == `ADR_C1)
        c1_q <= reg_wdata_i;
      if (reg_addr_i == `ADR_C2)
        c2e_q <= reg_wdata_i[7:4];
      if (reg_addr_i == `ADR_S2)
        s2e_q <= reg_wdata_i[3:2];
      if (reg_addr_i == `ADR_C3)
        inv_q <= reg_wdata_i[4];
      // any transmitter or break activity ends the quiet-line guarantee
      if (reg_addr_i == `ADR_C2 && (reg_wdata_i[3] || reg_wdata_i[0]))
        tx_used_q <= 1'b1;
    end
  end
  // ****
  // assertions
  // ****
  property rb(x, a, m);
    (reg_wr_i && xbus_sel_i == x && reg_addr_i == a) ##1
    (reg_rd_i && !reg_wr_i && xbus_sel_i == x && reg_addr_i == a)
    |=> ((reg_rdata_o ^ $past(reg_wdata_i, 2)) & m) == 8'h00;
  endproperty
  reset_values_a:
    assert property ($fell(rst_i) |-> reg_rdata_o == `RST_DATA && txd_o && !irq_o)
    else $error("outputs not at reset values");
  read_hold_a:
    assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  ctrl_two_rb_a:
    assert property (rb(1'b0, `ADR_C2, 8'hfc))
    else $error("control two readback wrong");
  ctrl_three_rb_a:
    assert property (rb(1'b0, `ADR_C3, 8'h7f))
    else $error("control three readback wrong");
  brk_ctrl_rb_a:
    assert property (rb(1'b0, `ADR_S2, 8'h0f))
    else $error("break control readback wrong");
  divisor_rb_a:
    assert property (rb(1'b1, `ADR_BDH, 8'h1f))
    else $error("divisor readback wrong");
  irq_gated_a:
    assert property (irq_o |-> c2e_q != 4'h0 || s2e_q != 2'h0 || $past(c2e_q) != 4'h0
      || $past(s2e_q) != 2'h0)
    else $error("interrupt without an enable");
  loop_release_a:
    assert property (c1_q[7] && !c1_q[5] && $past(c1_q[7] && !c1_q[5]) |-> txd_oe_n_o)
    else $error("pin driven in internal loopback");
  two_wire_drive_a:
    assert property (!c1_q[7] && $past(!c1_q[7]) |-> !txd_oe_n_o)
    else $error("pin not driven in two-wire mode");
  quiet_level_a:
    assert property (!tx_used_q && inv_q == $past(inv_q) |-> txd_o == !inv_q)
    else $error("quiet line level wrong");
  cover property ($rose(irq_o));
  cover property ($fell(txd_o));
  cover property (txd_oe_n_o);
endmodule
bind uart_regs uart_regs_monitor uart_regs_monitor_i (
  .sys_clk_i, .rst_i, .xbus_sel_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .reg_rdata_o, .rxd_i, .txd_i, .txd_o, .txd_oe_n_o, .irq_o
);

// >>> test/uart_remote.sv
/*
  remote serial transceiver at the far end of the line.
  assumes one bit lasts BIT_CLKS cycles of the shared clock; line pulled high.
*/
module uart_remote #(
  parameter int BIT_CLKS = 16
) (
  input wire logic sys_clk_i,
  input wire logic pin_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd_o = 1'b1;
  // first bit of f goes out first; line back to idle high afterwards
  task automatic send_bits(input logic [15:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd_o = f[i];
      repeat (BIT_CLKS) @(posedge sys_clk_i);
      #1;
    end
    // one idle bit time so back-to-back frames never change the line twice at once
    rxd_o = 1'b1;
    repeat (BIT_CLKS) @(posedge sys_clk_i);
    #1;
  endtask
  // bounded wait so a silent transmitter cannot hang the run
  task automatic wait_low(output bit ok);
    int w;
    w = 0;
    while (pin_i && w < 4000)
    begin
      @(posedge sys_clk_i);
      w++;
    end
    ok = !pin_i;
  endtask
  task automatic get_frame(output logic [7:0] d);
    bit ok;
    d = 8'hxx;
    wait_low(ok);
    if (ok)
    begin
      repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge sys_clk_i);
      for (int i = 0; i < 8; i++)
      begin
        d[i] = pin_i;
        repeat (BIT_CLKS) @(posedge sys_clk_i);
      end
    end
    #1;
  endtask
  task automatic low_len(output int n);
    bit ok;
    n = 0;
    wait_low(ok);
    while (ok && !pin_i && n < 1000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    #1;
  endtask
endmodule

// >>> test/test_uart_regs.sv
/*
  register-level testbench of the serial port with a remote transceiver.
  assumes divisor 1, so one bit is sixteen clocks.
*/
`include "uart_cfg.svh"
`define CHK(got, exp, msg) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("wrong value at %0t ns: %s", $time, msg); \
    end \
  end
module test_uart_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_i, xbus_sel_i, reg_wr_i, reg_rd_i, rxd, txd_o, txd_oe_n_o, irq_o, pin;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  int fail_count = 0;
  int comparisons = 0;
  int n;
  logic [8:0] rst_adr [10] = '{9'h098, 9'h0ba, 9'h0bb, 9'h0bc, 9'h0bd, 9'h0c2, 9'h0ed,
    9'h160, 9'h161, 9'h000};
  logic [7:0] rst_val [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  logic [7:0] err_c1 [3] = '{8'h09, 8'h0d, 8'h01};
  logic [9:0] err_fr [3] = '{10'h202, 10'h202, 10'h0aa};
  logic [7:0] err_ex [3] = '{8'h01, 8'h00, 8'h02};
  int brk_len [3] = '{10 * 16, 13 * 16, 12 * 16};
  always #2 sys_clk_i = ~sys_clk_i;
  assign pin = txd_oe_n_o ? 1'b1 : txd_o;
  uart_regs uart_regs_i (
    .sys_clk_i, .rst_i, .xbus_sel_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .rxd_i(rxd), .txd_i(pin), .txd_o, .txd_oe_n_o, .irq_o
  );
  uart_remote uart_remote_i (.sys_clk_i, .pin_i(pin), .rxd_o(rxd));
  // ****
  // bus and helper tasks
  // ****
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  // strobe dropped by non-blocking at the taking edge, so back-to-back calls are safe
  task automatic wr(input logic x, input logic [7:0] a, input logic [7:0] v);
    xbus_sel_i = x;
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic x, input logic [7:0] a, output logic [7:0] v);
    xbus_sel_i = x;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask
  task automatic rdc(input logic x, input logic [7:0] a, m, e, input string msg);
    logic [7:0] v;
    rd(x, a, v);
    `CHK(v & m, e, msg)
  endtask
  task automatic wrc(input logic x, input logic [7:0] a, v, e);
    wr(x, a, v);
    rdc(x, a, 8'hff, e, "readback");
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge sys_clk_i);
    fail_count++;
    give_verdict();
  end
  // ****
  // scenarios
  // ****
  initial
  begin
    {rst_i, xbus_sel_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {1'b1, 19'h00000};
    cyc(4);
    rst_i = 1'b0;
    for (int i = 0; i < 10; i++)
      rdc(rst_adr[i][8], rst_adr[i][7:0], 8'hff, rst_val[i], "reset value");
    wrc(1'b1, `ADR_BDH, 8'h1f, 8'h1f);
    wrc(1'b1, `ADR_BDL, 8'hff, 8'hff);
    wr(1'b1, `ADR_BDH, 8'h00);
    wr(1'b1, `ADR_BDL, 8'h01);
    wrc(1'b0, `ADR_C1, 8'h01, 8'h01);
    wrc(1'b0, `ADR_C2, 8'h2c, 8'h2c);
    cyc(4);
    rdc(1'b0, `ADR_FLAGS, 8'hc0, 8'hc0, "tx idle flags");
    wr(1'b0, `ADR_DATA, 8'ha5);
    uart_remote_i.get_frame(d);
    `CHK(d, 8'ha5, "sent byte")
    rdc(1'b0, `ADR_FLAGS, 8'h40, 8'h00, "tx busy");
    cyc(40);
    rdc(1'b0, `ADR_FLAGS, 8'h40, 8'h40, "tx done");
    uart_remote_i.send_bits({7'h7f, 8'h3c, 1'b0}, 10);
    cyc(4);
    `CHK(irq_o, 1'b1, "rx irq")
    rdc(1'b0, `ADR_FLAGS, 8'h20, 8'h20, "rx full");
    rdc(1'b0, `ADR_DATA, 8'hff, 8'h3c, "rx byte");
    rdc(1'b0, `ADR_FLAGS, 8'h20, 8'h00, "rx empty");
    `CHK(irq_o, 1'b0, "rx irq gone")
    cyc(192);
    rdc(1'b0, `ADR_FLAGS, 8'h10, 8'h10, "idle seen");
    wr(1'b0, `ADR_CLR, 8'h00);
    rdc(1'b0, `ADR_FLAGS, 8'h10, 8'h10, "idle kept");
    wr(1'b0, `ADR_CLR, 8'h10);
    rdc(1'b0, `ADR_FLAGS, 8'h10, 8'h00, "idle cleared");
    uart_remote_i.send_bits({7'h7f, 8'h11, 1'b0}, 10);
    uart_remote_i.send_bits({7'h7f, 8'h22, 1'b0}, 10);
    cyc(4);
    rdc(1'b0, `ADR_FLAGS, 8'h28, 8'h28, "overrun");
    rdc(1'b0, `ADR_DATA, 8'hff, 8'h11, "old byte kept");
    wr(1'b0, `ADR_CLR, 8'h08);
    rdc(1'b0, `ADR_FLAGS, 8'h08, 8'h00, "overrun cleared");
    for (int i = 0; i < 3; i++)
    begin
      wr(1'b0, `ADR_C1, err_c1[i]);
      uart_remote_i.send_bits({6'h3f, err_fr[i]}, 10);
      cyc(4);
      rdc(1'b0, `ADR_FLAGS, 8'h07, err_ex[i], "error flags");
      rd(1'b0, `ADR_DATA, d);
      wr(1'b0, `ADR_CLR, 8'hff);
    end
    wr(1'b0, `ADR_C2, 8'h0c);
    wr(1'b0, `ADR_S2, 8'h49);
    rdc(1'b0, `ADR_S2, 8'h4f, 8'h09, "edge cleared");
    uart_remote_i.send_bits(16'h0000, 13);
    cyc(4);
    rdc(1'b0, `ADR_S2, 8'hc0, 8'hc0, "break and edge");
    `CHK(irq_o, 1'b1, "break irq")
    wr(1'b0, `ADR_S2, 8'h09);
    rdc(1'b0, `ADR_S2, 8'h80, 8'h80, "zero leaves flag");
    wr(1'b0, `ADR_S2, 8'hc9);
    rdc(1'b0, `ADR_S2, 8'hc0, 8'h00, "flags cleared");
    `CHK(irq_o, 1'b0, "break irq gone")
    for (int i = 0; i < 3; i++)
    begin
      if (i == 2)
        wr(1'b0, `ADR_C1, 8'h51);
      wr(1'b0, `ADR_S2, {6'h00, i[0], 1'b0});
      wr(1'b0, `ADR_C2, 8'h0d);
      wr(1'b0, `ADR_C2, 8'h0c);
      uart_remote_i.low_len(n);
      `CHK(n >= brk_len[i] - 2 && n <= brk_len[i] + 2, 1'b1, "break length")
    end
    wr(1'b0, `ADR_C1, 8'h01);
    wr(1'b0, `ADR_C2, 8'h04);
    wr(1'b0, `ADR_DATA, 8'h77);
    uart_remote_i.low_len(n);
    `CHK(n, 0, "line stays quiet")
    wrc(1'b0, `ADR_C3, 8'h50, 8'h50);
    cyc(3);
    `CHK(txd_o, 1'b0, "inverted idle")
    rd(1'b0, `ADR_DATA, d);
    wr(1'b0, `ADR_C3, 8'h01);
    wr(1'b0, `ADR_C2, 8'h0e);
    uart_remote_i.send_bits({7'h7f, 8'h12, 1'b0}, 10);
    cyc(4);
    rdc(1'b0, `ADR_FLAGS, 8'h20, 8'h00, "standby ignores");
    uart_remote_i.send_bits({7'h7f, 8'h92, 1'b0}, 10);
    cyc(4);
    rdc(1'b0, `ADR_DATA, 8'hff, 8'h92, "address wakes");
    rdc(1'b0, `ADR_C2, 8'h02, 8'h00, "standby left");
    wr(1'b0, `ADR_C3, 8'h00);
    wr(1'b0, `ADR_C2, 8'h0c);
    wrc(1'b0, `ADR_C1, 8'h81, 8'h81);
    cyc(2);
    `CHK(txd_oe_n_o, 1'b1, "pin released")
    wr(1'b0, `ADR_DATA, 8'h5a);
    cyc(200);
    rdc(1'b0, `ADR_DATA, 8'hff, 8'h5a, "looped byte");
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    rdc(1'b0, `ADR_C2, 8'hff, 8'h00, "second reset");
    give_verdict();
  end
endmodule
